// >>> verilog/ttmc_cfg.svh
// Constants of the tone test mode controller: tone codes, durations, step numbers.
// Assumes tone codes are frequencies in whole Hz and durations count one-second ticks.
`ifndef TTMC_CFG_SVH
`define TTMC_CFG_SVH
`define TTMC_FW          12
`define TTMC_F304        12'h130
`define TTMC_F404        12'h194
`define TTMC_F408        12'h198
`define TTMC_F604        12'h25C
`define TTMC_F1008       12'h3F0
`define TTMC_F1713       12'h6B1
`define TTMC_F1808       12'h710
`define TTMC_F1913       12'h779
`define TTMC_F2413       12'h96D
`define TTMC_F2604       12'hA2C
`define TTMC_F2713       12'hA99
`define TTMC_F2808       12'hAF8
`define TTMC_F3604       12'hE14
`define TTMC_FOFF        12'h000
`define TTMC_QUAL_S      6'h05
`define TTMC_ACT_CMD_S   6'h1E
`define TTMC_SWEEP_S     11'h00F
`define TTMC_RX_FIRST_S  11'h03C
`define TTMC_IDLE_TO_S   11'h4B0
`define TTMC_TX_LAST     3'h3
`define TTMC_RX_QUIET    3'h1
`define TTMC_RX_LAST     3'h4
`define TTMC_PORT_LINE_TX 1'h0
`define TTMC_PORT_LINE_RX 1'h1
`endif

// >>> verilog/ttmc_pkg.sv
// Types shared by the tone test mode controller modules.
// Assumes nothing of its surroundings.
package ttmc_pkg;
  typedef enum logic [2:0] {
    TTMC_ST_IDLE   = 3'h0,
    TTMC_ST_CMD    = 3'h1,
    TTMC_ST_QT     = 3'h2,
    TTMC_ST_SWP_TX = 3'h3,
    TTMC_ST_XPDR   = 3'h4,
    TTMC_ST_SWP_RX = 3'h5
  } ttmc_state_t;
endpackage

// >>> verilog/ttmc_tone_if.sv
// Bundle between the controller and its tone presence tracker.
// Assumes one clock; the controller drives valid, freq and tick.
`timescale 1ns/1ns
`default_nettype none
interface ttmc_tone_if #(
  parameter int FW      = 12,
  parameter int DWELL_W = 6
);
  logic               valid;
  logic [FW-1:0]      freq;
  logic               tick;
  logic               new_tone;
  logic [DWELL_W-1:0] dwell;
  modport det (input valid, input freq, input tick, output new_tone, output dwell);
  modport ctl (input valid, input freq, input tick, input new_tone, input dwell);
endinterface
`default_nettype wire

// >>> verilog/ttmc_presence.sv
// Tone presence tracker: flags the start of each tone and counts its seconds.
// Assumes the detector's valid and freq are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ttmc_presence #(
  parameter int FW      = 12,
  parameter int DWELL_W = 6
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  ttmc_tone_if.det  tif
);
  typedef struct packed {
    logic               seen;
    logic [FW-1:0]      last;
    logic [DWELL_W-1:0] dwell;
  } ttmc_pres_t;

  ttmc_pres_t r;
  ttmc_pres_t n;
  logic       fresh;

  if (DWELL_W < 6) begin : g_dwell_chk
    $error("DWELL_W too narrow for a 30 s dwell");
  end

  // A change of frequency counts as a new tone even without a gap
  assign fresh        = tif.valid && (!r.seen || (tif.freq != r.last));
  assign tif.new_tone = fresh;
  assign tif.dwell    = fresh ? '0 : r.dwell;

  always_comb begin
    n      = r;
    n.seen = tif.valid;
    n.last = tif.freq;
    if (!tif.valid || fresh) begin
      n.dwell = '0;
    end else if (tif.tick && (r.dwell != '1)) begin
      n.dwell = DWELL_W'(r.dwell + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  property p_new_clears;
    @(posedge clk) disable iff (sys_rst)
    (tif.new_tone && !tif.tick) ##1 (tif.valid && !tif.new_tone) |-> tif.dwell == '0;
  endproperty
  a_new_clears: assert property (p_new_clears) else $error("dwell not restarted");
endmodule
`default_nettype wire

// >>> verilog/ttmc_sec_timer.sv
// Seconds counter for state durations and inactivity, saturating at all ones.
// Assumes tick is a one-cycle pulse once per second.
`timescale 1ns/1ns
`default_nettype none
module ttmc_sec_timer #(
  parameter int SEC_W = 11
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clr,
  input  wire logic             tick,
  output logic      [SEC_W-1:0] count
);
  typedef struct packed {
    logic [SEC_W-1:0] count;
  } ttmc_tmr_t;

  ttmc_tmr_t r;
  ttmc_tmr_t n;

  if (SEC_W < 11) begin : g_sec_chk
    $error("SEC_W too narrow for the 20 minute timeout");
  end

  always_comb begin
    n = r;
    if (clr) begin
      n.count = '0;
    end else if (tick && (r.count != '1)) begin
      n.count = SEC_W'(r.count + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign count = r.count;
endmodule
`default_nettype wire

// >>> verilog/ttmc_ctrl.sv
// Tone test mode controller: command, quiet termination, sweeps and transponder.
// Assumes a tone detector giving valid/frequency in Hz and a one-second tick.
`timescale 1ns/1ns
`default_nettype none
`include "ttmc_cfg.svh"
module ttmc_ctrl #(
  parameter int DWELL_W = 6,
  parameter int SEC_W   = 11
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 tone_valid,
  input  wire logic [`TTMC_FW-1:0]  tone_freq,
  input  wire logic                 sec_tick,
  input  wire logic [1:0]           act_sel,
  output logic                      gen_on,
  output logic      [`TTMC_FW-1:0]  gen_freq,
  output logic                      gen_echo,
  output logic                      gen_port,
  output logic                      quiet_term,
  output logic                      modem_isolate,
  output ttmc_pkg::ttmc_state_t     test_state
);
  typedef struct packed {
    ttmc_pkg::ttmc_state_t st;
    logic [2:0]            step;
    logic                  ans;
    logic [`TTMC_FW-1:0]   afreq;
    logic                  gen_on;
    logic [`TTMC_FW-1:0]   gen_freq;
    logic                  gen_echo;
    logic                  gen_port;
    logic                  quiet_term;
    logic                  modem_isolate;
  } ttmc_ctl_t;

  ttmc_ctl_t           r;
  ttmc_ctl_t           n;
  logic                tmr_clr;
  logic [SEC_W-1:0]    tmr;
  logic [`TTMC_FW-1:0] act_f;
  logic                is_act;
  logic                act_q;
  logic                ret_q;
  logic                cmd_q;

  ttmc_tone_if #(.FW(`TTMC_FW), .DWELL_W(DWELL_W)) tif ();

  assign tif.valid = tone_valid;
  assign tif.freq  = tone_freq;
  assign tif.tick  = sec_tick;

  ttmc_presence #(.FW(`TTMC_FW), .DWELL_W(DWELL_W)) u_pres (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tif     (tif.det)
  );

  ttmc_sec_timer #(.SEC_W(SEC_W)) u_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (tmr_clr),
    .tick    (sec_tick),
    .count   (tmr)
  );

  function automatic logic [`TTMC_FW-1:0] act_freq(input logic [1:0] sel);
    case (sel)
      2'h0:    act_freq = `TTMC_F1713;
      2'h1:    act_freq = `TTMC_F1913;
      2'h2:    act_freq = `TTMC_F2413;
      default: act_freq = `TTMC_F2713;
    endcase
  endfunction

  // Transponder tones: the band minus the return command and the selected activation tone
  function automatic logic xp_ok(input logic [`TTMC_FW-1:0] f, input logic [`TTMC_FW-1:0] a);
    xp_ok = (f >= `TTMC_F304) && (f <= `TTMC_F3604) && (f != `TTMC_F2604) && (f != a);
  endfunction

  function automatic logic [`TTMC_FW-1:0] tx_tone(input logic [2:0] s);
    case (s)
      3'h0:    tx_tone = `TTMC_F408;
      3'h1:    tx_tone = `TTMC_F1008;
      3'h2:    tx_tone = `TTMC_F1808;
      default: tx_tone = `TTMC_F2808;
    endcase
  endfunction

  function automatic logic [`TTMC_FW-1:0] rx_tone(input logic [2:0] s);
    case (s)
      3'h0:    rx_tone = `TTMC_F1008;
      3'h2:    rx_tone = `TTMC_F408;
      3'h3:    rx_tone = `TTMC_F1808;
      3'h4:    rx_tone = `TTMC_F2808;
      default: rx_tone = `TTMC_FOFF;
    endcase
  endfunction

  function automatic logic [SEC_W-1:0] rx_len(input logic [2:0] s);
    rx_len = (s == 3'h0) ? SEC_W'(`TTMC_RX_FIRST_S) : SEC_W'(`TTMC_SWEEP_S);
  endfunction

  assign act_f  = act_freq(act_sel);
  assign is_act = tif.valid && (tif.freq == act_f);
  assign act_q  = is_act && (tif.dwell > DWELL_W'(`TTMC_QUAL_S));
  assign ret_q  = tif.valid && (tif.freq == `TTMC_F2604) &&
                  (tif.dwell > DWELL_W'(`TTMC_QUAL_S));
  assign cmd_q  = is_act && (tif.dwell > DWELL_W'(`TTMC_ACT_CMD_S));

  always_comb begin
    n       = r;
    tmr_clr = 1'b0;
    case (r.st)
      ttmc_pkg::TTMC_ST_IDLE: begin
        if (cmd_q) begin
          n.st    = ttmc_pkg::TTMC_ST_CMD;
          tmr_clr = 1'b1;
        end
      end
      ttmc_pkg::TTMC_ST_CMD: begin
        if (tif.new_tone && (tif.freq == `TTMC_F404)) begin
          n.st    = ttmc_pkg::TTMC_ST_QT;
          tmr_clr = 1'b1;
        end else if (tif.new_tone && (tif.freq == `TTMC_F604)) begin
          n.st    = ttmc_pkg::TTMC_ST_SWP_RX;
          n.step  = 3'h0;
          tmr_clr = 1'b1;
        end
      end
      ttmc_pkg::TTMC_ST_QT: begin
        if (act_q) begin
          n.st = ttmc_pkg::TTMC_ST_IDLE;
        end else if (ret_q) begin
          n.st    = ttmc_pkg::TTMC_ST_CMD;
          tmr_clr = 1'b1;
        end else if (tif.new_tone && (tif.freq == `TTMC_F404)) begin
          n.st    = ttmc_pkg::TTMC_ST_SWP_TX;
          n.step  = 3'h0;
          tmr_clr = 1'b1;
        end else if (tif.new_tone && xp_ok(tif.freq, act_f)) begin
          n.st    = ttmc_pkg::TTMC_ST_XPDR;
          n.ans   = 1'b1;
          n.afreq = tif.freq;
          tmr_clr = 1'b1;
        end else if (tif.valid) begin
          tmr_clr = 1'b1;
        end else if (tmr >= SEC_W'(`TTMC_IDLE_TO_S)) begin
          n.st = ttmc_pkg::TTMC_ST_IDLE;
        end
      end
      ttmc_pkg::TTMC_ST_SWP_TX: begin
        if (act_q) begin
          n.st = ttmc_pkg::TTMC_ST_IDLE;
        end else if (ret_q) begin
          n.st    = ttmc_pkg::TTMC_ST_CMD;
          tmr_clr = 1'b1;
        end else if (tmr >= SEC_W'(`TTMC_SWEEP_S)) begin
          tmr_clr = 1'b1;
          if (r.step == `TTMC_TX_LAST) begin
            n.st = ttmc_pkg::TTMC_ST_QT;
          end else begin
            n.step = 3'(r.step + 3'h1);
          end
        end
      end
      ttmc_pkg::TTMC_ST_XPDR: begin
        if (act_q) begin
          n.st  = ttmc_pkg::TTMC_ST_IDLE;
          n.ans = 1'b0;
        end else if (ret_q) begin
          n.st    = ttmc_pkg::TTMC_ST_CMD;
          n.ans   = 1'b0;
          tmr_clr = 1'b1;
        end else if (tif.new_tone && xp_ok(tif.freq, act_f)) begin
          // 404 Hz lands here too and is simply echoed
          n.ans   = 1'b1;
          n.afreq = tif.freq;
          tmr_clr = 1'b1;
        end else if (r.ans) begin
          // Timer measures the answer; a long tone keeps it going past 15 s
          if (!tif.valid && (tmr >= SEC_W'(`TTMC_SWEEP_S))) begin
            n.ans   = 1'b0;
            tmr_clr = 1'b1;
          end
        end else if (tif.valid) begin
          tmr_clr = 1'b1;
        end else if (tmr >= SEC_W'(`TTMC_IDLE_TO_S)) begin
          n.st = ttmc_pkg::TTMC_ST_IDLE;
        end
      end
      ttmc_pkg::TTMC_ST_SWP_RX: begin
        if (act_q) begin
          n.st = ttmc_pkg::TTMC_ST_IDLE;
        end else if (tmr >= rx_len(r.step)) begin
          tmr_clr = 1'b1;
          if (r.step == `TTMC_RX_LAST) begin
            n.st = ttmc_pkg::TTMC_ST_CMD;
          end else begin
            n.step = 3'(r.step + 3'h1);
          end
        end
      end
      default: begin
        n.st  = ttmc_pkg::TTMC_ST_IDLE;
        n.ans = 1'b0;
      end
    endcase

    // Outputs follow the next state so they line up with test_state
    n.gen_on        = 1'b0;
    n.gen_echo      = 1'b0;
    n.gen_freq      = `TTMC_FOFF;
    n.gen_port      = `TTMC_PORT_LINE_TX;
    n.quiet_term    = (n.st == ttmc_pkg::TTMC_ST_QT) || (n.st == ttmc_pkg::TTMC_ST_SWP_TX) ||
                      (n.st == ttmc_pkg::TTMC_ST_XPDR);
    n.modem_isolate = n.quiet_term;
    case (n.st)
      ttmc_pkg::TTMC_ST_SWP_TX: begin
        n.gen_on   = 1'b1;
        n.gen_freq = tx_tone(n.step);
      end
      ttmc_pkg::TTMC_ST_XPDR: begin
        n.gen_on   = n.ans;
        n.gen_echo = n.ans;
        n.gen_freq = n.ans ? n.afreq : `TTMC_FOFF;
      end
      ttmc_pkg::TTMC_ST_SWP_RX: begin
        n.gen_port = `TTMC_PORT_LINE_RX;
        n.gen_on   = (n.step != `TTMC_RX_QUIET);
        n.gen_freq = rx_tone(n.step);
      end
      default: begin
        n.gen_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign gen_on        = r.gen_on;
  assign gen_freq      = r.gen_freq;
  assign gen_echo      = r.gen_echo;
  assign gen_port      = r.gen_port;
  assign quiet_term    = r.quiet_term;
  assign modem_isolate = r.modem_isolate;
  assign test_state    = r.st;

  sequence s_act_held;
    is_act && (tif.dwell > DWELL_W'(`TTMC_QUAL_S));
  endsequence

  sequence s_qt_fresh;
    (r.st == ttmc_pkg::TTMC_ST_QT) && (tmr == '0) && quiet_term;
  endsequence

  sequence s_tx_wrap;
    (r.st == ttmc_pkg::TTMC_ST_SWP_TX) && (r.step == `TTMC_TX_LAST) &&
    (tmr >= SEC_W'(`TTMC_SWEEP_S)) && !act_q && !ret_q;
  endsequence

  property p_cmd_qt;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_CMD) && tif.new_tone && (tif.freq == `TTMC_F404)
    |=> (r.st == ttmc_pkg::TTMC_ST_QT) && !gen_on;
  endproperty
  a_cmd_qt: assert property (p_cmd_qt) else $error("404 Hz in command missed");

  property p_qt_term;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_QT) |-> quiet_term && modem_isolate && !gen_on;
  endproperty
  a_qt_term: assert property (p_qt_term) else $error("quiet term not applied");

  property p_qt_timeout;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_QT) && !tone_valid && (tmr >= SEC_W'(`TTMC_IDLE_TO_S))
    |=> (r.st == ttmc_pkg::TTMC_ST_IDLE) && !quiet_term;
  endproperty
  a_qt_timeout: assert property (p_qt_timeout) else $error("quiet term did not time out");

  property p_qt_ret;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_QT) && ret_q |=> (r.st == ttmc_pkg::TTMC_ST_CMD);
  endproperty
  a_qt_ret: assert property (p_qt_ret) else $error("2604 Hz did not return to command");

  property p_act_idle;
    @(posedge clk) disable iff (sys_rst)
    (r.st != ttmc_pkg::TTMC_ST_IDLE) && (r.st != ttmc_pkg::TTMC_ST_CMD) ##0 s_act_held
    |=> (r.st == ttmc_pkg::TTMC_ST_IDLE) && !gen_on;
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("activation tone did not idle");

  property p_sub_entry;
    @(posedge clk) disable iff (sys_rst)
    ((r.st == ttmc_pkg::TTMC_ST_SWP_TX) || (r.st == ttmc_pkg::TTMC_ST_XPDR)) &&
    ($past(r.st) != r.st) |-> ($past(r.st) == ttmc_pkg::TTMC_ST_QT);
  endproperty
  a_sub_entry: assert property (p_sub_entry) else $error("sub-mode entered wrongly");

  property p_tx_order;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_SWP_TX) |-> gen_on && (gen_port == `TTMC_PORT_LINE_TX) &&
    (gen_freq == tx_tone(r.step));
  endproperty
  a_tx_order: assert property (p_tx_order) else $error("wrong sweep tone");

  property p_tx_back;
    @(posedge clk) disable iff (sys_rst)
    s_tx_wrap |=> s_qt_fresh;
  endproperty
  a_tx_back: assert property (p_tx_back) else $error("sweep did not restore quiet");

  property p_qt_sweep;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_QT) && tif.new_tone && (tif.freq == `TTMC_F404)
    |=> (r.st == ttmc_pkg::TTMC_ST_SWP_TX) && (r.step == 3'h0) && (gen_freq == `TTMC_F408);
  endproperty
  a_qt_sweep: assert property (p_qt_sweep) else $error("404 Hz did not start sweep");

  property p_xp_404;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_XPDR) && tif.new_tone && (tif.freq == `TTMC_F404)
    |=> (r.st == ttmc_pkg::TTMC_ST_XPDR) && gen_echo && (gen_freq == `TTMC_F404);
  endproperty
  a_xp_404: assert property (p_xp_404) else $error("404 Hz not echoed");

  property p_xp_hold;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_XPDR) && r.ans && (tmr < SEC_W'(`TTMC_SWEEP_S)) &&
    !act_q && !ret_q |=> gen_on && gen_echo;
  endproperty
  a_xp_hold: assert property (p_xp_hold) else $error("echo ended before 15 s");

  property p_xp_end;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_XPDR) && r.ans && !tone_valid &&
    (tmr >= SEC_W'(`TTMC_SWEEP_S)) |=> !gen_on && quiet_term && (tmr == '0);
  endproperty
  a_xp_end: assert property (p_xp_end) else $error("echo did not end");

  property p_rx_start;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_CMD) && tif.new_tone && (tif.freq == `TTMC_F604)
    |=> (r.st == ttmc_pkg::TTMC_ST_SWP_RX) && (gen_freq == `TTMC_F1008) &&
    (gen_port == `TTMC_PORT_LINE_RX);
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("604 Hz did not start sweep");

  property p_rx_end;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_SWP_RX) && (r.step == `TTMC_RX_LAST) &&
    (tmr >= SEC_W'(`TTMC_SWEEP_S)) && !act_q |=> (r.st == ttmc_pkg::TTMC_ST_CMD) && !gen_on;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("receive sweep did not finish");

  property p_idle_cmd;
    @(posedge clk) disable iff (sys_rst)
    (r.st == ttmc_pkg::TTMC_ST_IDLE) && cmd_q |=> (r.st == ttmc_pkg::TTMC_ST_CMD);
  endproperty
  a_idle_cmd: assert property (p_idle_cmd) else $error("30 s activation missed");
endmodule
`default_nettype wire

// >>> tb/ttmc_tester_model.sv
// Remote tester as seen through the tone detector, plus a fast one-second tick.
// Assumes the bench changes req_on and req_freq just after a falling edge.
`timescale 1ns/1ns
`default_nettype none
module ttmc_tester_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic        clk,
  input  wire logic        req_on,
  input  wire logic [11:0] req_freq,
  output logic             tone_valid,
  output logic      [11:0] tone_freq,
  output logic             sec_tick,
  output int               phase
);
  logic [11:0] last_r = 12'h000;
  // Tick moves off the rising edge so the controller samples it cleanly
  always @(negedge clk) phase <= (phase + 1) % TICK_DIV;
  always @(posedge clk) if (req_on) last_r <= req_freq;
  // With no tone the detector code means nothing; never show the old one
  assign tone_valid = req_on;
  assign tone_freq  = req_on ? req_freq : ~last_r;
  assign sec_tick   = phase == 0;
endmodule
`default_nettype wire

// >>> tb/tone_test_mode_controller_tb.sv
// Self-checking bench of the tone test mode controller against a small reference model.
// Assumes the tester model supplies tones and a one-second tick every four clocks.
`timescale 1ns/1ns
`default_nettype none
`include "ttmc_cfg.svh"
module tone_test_mode_controller_tb;
  logic                  clk, sys_rst, req_on, tone_valid, sec_tick;
  logic                  gen_on, gen_echo, gen_port, quiet_term, modem_isolate;
  logic [1:0]            act_sel;
  logic [11:0]           req_freq, tone_freq, gen_freq, m_st, m_f, f;
  logic [31:0]           lfsr;
  ttmc_pkg::ttmc_state_t test_state;
  int                    tm_phase, err_total, n_checks, t, s;
  int                    steps[$];
  logic [11:0]           act_tbl[4] = '{`TTMC_F1713, `TTMC_F1913, `TTMC_F2413, `TTMC_F2713};

  ttmc_tester_model ttmc_tester_model_i (.clk(clk), .req_on(req_on), .req_freq(req_freq),
    .tone_valid(tone_valid), .tone_freq(tone_freq), .sec_tick(sec_tick), .phase(tm_phase));
  ttmc_ctrl ttmc_ctrl_i (.clk(clk), .sys_rst(sys_rst), .tone_valid(tone_valid),
    .tone_freq(tone_freq), .sec_tick(sec_tick), .act_sel(act_sel), .gen_on(gen_on),
    .gen_freq(gen_freq), .gen_echo(gen_echo), .gen_port(gen_port), .quiet_term(quiet_term),
    .modem_isolate(modem_isolate), .test_state(test_state));

  always #10 clk = ~clk;

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Probe tones sit on the 100 Hz grid and keep off the 404 Hz and 2604 Hz command tones
  function automatic logic [11:0] pick();
    logic [11:0] p;
    lfsr = nxt(lfsr);
    p = 12'(304 + 100 * (lfsr % 33));
    return (p == `TTMC_F404 || p == `TTMC_F2604) ? 12'h3EC : p;
  endfunction

  task automatic summarize();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic model();
    chk("state", 12'(test_state), m_st);
    chk("freq", gen_freq, m_f);
    chk("on", 12'(gen_on), 12'(m_f != 0));
    chk("port", 12'(gen_port), 12'(m_st == 5));
    chk("echo", 12'(gen_echo), 12'(m_st == 4 && m_f != 0));
    if (m_st != 5) chk("quiet", 12'(quiet_term), 12'(m_st inside {2, 3, 4}));
    chk("isolate", 12'(modem_isolate), 12'(m_st inside {2, 3, 4}));
  endtask

  task automatic wchg(input bit by_st, input logic [11:0] v, input int lim);
    int n;
    t = 0;
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      if (sec_tick === 1'b1) t++;
      #1;
      if ((by_st ? 12'(test_state) : gen_freq) !== v) break;
    end
    if (n == lim) begin
      err_total++;
      $display("[ERR] wait exp change from %h seen none", v);
      summarize();
    end
  endtask

  task automatic tone(input logic on, input logic [11:0] fr, input bit pulse);
    int n;
    @(negedge clk);
    for (n = 0; n < 8 && tm_phase != 0; n++) @(negedge clk);
    req_on = on;
    req_freq = fr;
    if (pulse) begin
      @(negedge clk);
      req_on = 1'b0;
    end
  endtask

  task automatic enter(input logic [11:0] fr, input logic [11:0] nst);
    tone(1'b1, fr, 1'b1);
    wchg(1'b1, m_st, 10);
    m_st = nst;
    m_f = nst == 3 ? `TTMC_F408 : nst == 4 ? fr : nst == 5 ? `TTMC_F1008 : 12'h000;
    model();
  endtask

  task automatic qual(input logic [11:0] fr, input logic [11:0] nst);
    tone(1'b1, fr, 1'b0);
    wchg(1'b1, m_st, 100);
    chk("qual_ticks", 12'(t), 12'h006);
    tone(1'b0, 12'h000, 1'b0);
    m_st = nst;
    m_f = 12'h000;
    model();
  endtask

  task automatic go_cmd();
    tone(1'b1, act_tbl[act_sel], 1'b0);
    wchg(1'b1, 12'h000, 200);
    chk("cmd_ticks", 12'(t), 12'h01F);
    tone(1'b0, 12'h000, 1'b0);
    m_st = 12'h001;
    model();
  endtask

  task automatic run_steps();
    int et;
    while (steps.size() > 1) begin
      m_f = 12'(steps.pop_front());
      et = steps.pop_front();
      model();
      wchg(1'b0, m_f, 300);
      chk("step_ticks", 12'(t), 12'(et));
    end
    m_f = 12'h000;
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    req_on = 1'b0;
    req_freq = 12'h000;
    act_sel = 2'h0;
    lfsr = 32'h0000D8CA;
    m_st = 12'h000;
    m_f = 12'h000;
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    model();
    for (s = 0; s < 4; s++) begin
      act_sel = 2'(s);
      lfsr = nxt(lfsr);
      tone(1'b1, act_tbl[(s + 1 + lfsr % 3) % 4], 1'b0);
      repeat (160) @(posedge clk);
      #1 model();
      tone(1'b0, 12'h000, 1'b0);
      go_cmd();
      tone(1'b1, 12'h3EC, 1'b1);
      repeat (8) @(posedge clk);
      #1 model();
      enter(`TTMC_F404, 12'h002);
      qual(act_tbl[s], 12'h000);
    end
    go_cmd();
    enter(`TTMC_F404, 12'h002);
    for (s = 0; s < 2; s++) begin
      enter(`TTMC_F404, 12'h003);
      steps = '{408, 15, 1008, 15, 1808, 15, 2808, 15};
      run_steps();
      m_st = 12'h002;
      model();
    end
    wchg(1'b1, m_st, 5000);
    chk("qt_timeout", 12'(t), 12'h4B0);
    go_cmd();
    enter(`TTMC_F404, 12'h002);
    qual(`TTMC_F2604, 12'h001);
    enter(`TTMC_F404, 12'h002);
    enter(pick(), 12'h004);
    tone(1'b1, `TTMC_F404, 1'b0);
    wchg(1'b0, m_f, 10);
    m_f = `TTMC_F404;
    model();
    repeat (80) @(posedge clk);
    #1 model();
    tone(1'b0, 12'h000, 1'b0);
    wchg(1'b0, m_f, 10);
    chk("quiet_after", 12'(quiet_term), 12'h001);
    f = pick();
    tone(1'b1, f, 1'b1);
    wchg(1'b0, 12'h000, 10);
    chk("echo_freq", gen_freq, f);
    wchg(1'b0, f, 200);
    chk("echo_ticks", 12'(t), 12'h00F);
    m_f = 12'h000;
    model();
    wchg(1'b1, 12'(test_state), 5000);
    chk("xpdr_timeout", 12'(t), 12'h4B0);
    m_st = 12'h000;
    model();
    go_cmd();
    for (s = 0; s < 2; s++) begin
      enter(`TTMC_F404, 12'h002);
      enter(pick(), 12'h004);
      qual(s == 0 ? `TTMC_F2604 : act_tbl[act_sel], 12'(s == 0));
    end
    go_cmd();
    for (s = 0; s < 2; s++) begin
      enter(`TTMC_F604, 12'h005);
      steps = '{1008, 60, 0, 15, 408, 15, 1808, 15, 2808, 15};
      run_steps();
      m_st = 12'h001;
      model();
    end
    enter(`TTMC_F604, 12'h005);
    qual(act_tbl[act_sel], 12'h000);
    go_cmd();
    enter(`TTMC_F404, 12'h002);
    enter(`TTMC_F404, 12'h003);
    qual(`TTMC_F2604, 12'h001);
    summarize();
  end
endmodule
`default_nettype wire
